/* logic/lin_ctrl_regs.svh */
// register addresses, field positions, reset values and sizes of the lin register set
`ifndef LIN_CTRL_REGS_SVH
`define LIN_CTRL_REGS_SVH

// directly mapped special function register addresses
`define SFR_CFG_ADDR        8'hC9
`define SFR_DATA_ADDR       8'hD2
`define SFR_INDEX_ADDR      8'hD3

// indirect core register indices
`define IDX_DATA_LAST       8'h07
`define IDX_CTRL            8'h08
`define IDX_STATUS          8'h09
`define IDX_ERROR           8'h0A
`define IDX_SIZE            8'h0B
`define IDX_DIV             8'h0C
`define IDX_MUL             8'h0D
`define IDX_ID              8'h0E

// configuration register fields and reset value
`define CFG_ENABLE_BIT      7
`define CFG_MASTER_BIT      6
`define CFG_AUTO_BAUD_SELECT_BIT       5
`define CFG_RESET           8'h60

// control register fields
`define CTRL_STOP_BIT       7
`define CTRL_SLEEP_BIT      6
`define CTRL_DIR_BIT        5
`define CTRL_ACK_BIT        4
`define CTRL_IRQ_FLAG_CLEAR_BIT     3
`define CTRL_ERROR_FLAGS_CLEAR_BIT     2
`define CTRL_WAKE_BIT       1
`define CTRL_START_BIT      0

// status and size register fields
`define ST_INT_BIT          3
`define ST_ERR_BIT          2
`define SIZE_ENH_BIT        7
`define SIZE_WRITE_MASK     8'h8F
`define ID_WRITE_MASK       8'h3F
`define ERR_SLAVE_MASK      5'h18
`define REG_RESET           8'h00

// frame data buffer
`define DATA_BYTES          8
`define RX_FIFO_DEPTH       32

`endif

/* logic/lin_ctrl_pkg.sv */
// types shared by the lin register set and its frame engine side
`default_nettype none
package lin_ctrl_pkg;

  // node role as held in the configuration register
  typedef enum logic [0:0] {
    ROLE_SLAVE  = 1'b0,
    ROLE_MASTER = 1'b1
  } role_e;

  // settings and action requests handed to the frame engine
  typedef struct packed {
    logic       iface_enable;
    logic       master_role;
    logic       auto_baud_active;
    logic       frame_direction;
    logic       sleep_request;
    logic       stop_pulse;
    logic       data_acknowledge;
    logic       wake_signal_request;
    logic       frame_start_request;
    logic       enhanced_checksum_select;
    logic [3:0] frame_length;
    logic [7:0] baud_divider_low_bits;
    logic [1:0] baud_prescaler;
    logic [4:0] baud_multiplier;
    logic       baud_divider_msb;
    logic [5:0] frame_id;
  } frame_ctrl_s;

  // state and events reported by the frame engine
  typedef struct packed {
    logic       bus_active;
    logic       idle_timeout;
    logic       abort;
    logic       data_request_flag;
    logic       wakeup;
    logic       done;
    logic       irq_event;
    logic       error_event;
    logic [4:0] error_bits;
    logic       ack_taken;
    logic       wake_sent;
    logic       frame_end;
  } engine_evt_s;

endpackage
`default_nettype wire

/* logic/byte_fifo.sv */
// synchronous fifo with valid and ready on both sides
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage array
  logic [AW:0]      wr_ptr_reg;       // write pointer with wrap bit
  logic [AW:0]      rd_ptr_reg;       // read pointer with wrap bit
  logic [AW:0]      count_next;       // occupancy after this cycle
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign count_next = wr_ptr_reg - rd_ptr_reg + (AW+1)'(push) - (AW+1)'(pop);

  // storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
    end
  end

  // ready is a flop so the source never sees a combinational path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* logic/lin_control_register_set.sv */
// lin controller register set: direct config, indirect core registers, action bits
//
// Functional notes
// - config bit 7 enables whole interface
// - config bit 6 selects master or slave
// - config bit 5 auto baud, slave only
// - config low five bits read zero
// - fifteen indirect registers, indices 0x00 to 0x0E
// - role-specific bits work only in their role; a held sleep, ack or start bit still drives the engine after a role change
// - eight data bytes hold frame bytes
// - slave stop bit halts until break, reads 0
// - slave sleep bit sleeps or wakes node
// - direction bit marks transmit or receive
// - slave acknowledge set by software, hardware clears
// - writing 1 clears interrupt pending flag
// - writing 1 clears error status and flags
// - wake request sends wakeup, then self-clears
// - master start request, cleared on end or error
// - data port accesses register named by index
`include "lin_ctrl_regs.svh"
`default_nettype none
module lin_control_register_set
  import lin_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // special function register port
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // frame engine settings and events
  output frame_ctrl_s            ctrl,
  input  wire engine_evt_s       evt,
  // transmit bytes toward the engine
  output logic      [63:0]       tx_bytes,
  // received byte stream from the engine
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic              rx_frame_start
);

  // configuration register fields
  logic        enable_reg;            // interface enable
  role_e       role_reg;              // node role
  logic        auto_baud_select_reg;             // automatic baud choice
  logic        auto_baud_reg;         // auto baud as the engine sees it, slave only
  logic [7:0]  index_reg;             // indirect index

  // control register fields
  logic        stop_reg;              // one-cycle stop pulse
  logic        sleep_reg;
  logic        dir_reg;
  logic        ack_reg;
  logic        wake_reg;
  logic        start_reg;

  // status and error flags held here
  logic        irq_flag_reg;          // interrupt pending
  logic        error_flag_reg;        // communication error
  logic [4:0]  err_bits_reg;          // error register bits

  // frame settings
  logic [7:0]  size_reg;
  logic [7:0]  div_reg;
  logic [7:0]  mul_reg;
  logic [5:0]  id_reg;

  // frame data buffer and receive fill pointer
  logic [7:0]  data_byte_reg [`DATA_BYTES];
  logic [2:0]  rx_ptr_reg;
  logic [2:0]  rx_ptr_eff;

  // decoded accesses
  logic        cfg_wr;
  logic        idx_wr;
  logic        core_wr;
  logic        ctrl_wr;
  logic        is_slave;
  logic        is_master;
  logic [7:0]  core_rdata;
  logic [7:0]  status_view;

  // fifo draining side
  logic [7:0]  fifo_byte;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        drain;

  assign is_slave  = (role_reg == ROLE_SLAVE);
  assign is_master = (role_reg == ROLE_MASTER);
  assign cfg_wr    = sfr_wr && (sfr_addr == `SFR_CFG_ADDR);
  assign idx_wr    = sfr_wr && (sfr_addr == `SFR_INDEX_ADDR);
  assign core_wr   = sfr_wr && (sfr_addr == `SFR_DATA_ADDR);
  assign ctrl_wr   = core_wr && (index_reg == `IDX_CTRL);

  // configuration register, low bits are not stored at all
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= 1'(`CFG_RESET >> `CFG_ENABLE_BIT);
      role_reg   <= role_e'(1'(`CFG_RESET >> `CFG_MASTER_BIT));
      auto_baud_select_reg  <= 1'(`CFG_RESET >> `CFG_AUTO_BAUD_SELECT_BIT);
      auto_baud_reg <= 1'b0;                                            // master at reset
    end else if (cfg_wr) begin
      auto_baud_reg <= sfr_wdata[`CFG_AUTO_BAUD_SELECT_BIT] && !sfr_wdata[`CFG_MASTER_BIT];
      enable_reg <= sfr_wdata[`CFG_ENABLE_BIT];
      role_reg   <= role_e'(sfr_wdata[`CFG_MASTER_BIT]);
      auto_baud_select_reg  <= sfr_wdata[`CFG_AUTO_BAUD_SELECT_BIT];
    end
  end

  // indirect index register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_reg <= `REG_RESET;
    end else if (idx_wr) begin
      index_reg <= sfr_wdata;
    end
  end

  // stop request: slave only, a single pulse, never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= ctrl_wr && is_slave && sfr_wdata[`CTRL_STOP_BIT];
    end
  end

  // sleep and direction bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_reg <= 1'b0;
      dir_reg   <= 1'b0;
    end else if (ctrl_wr) begin
      if (is_slave) begin
        sleep_reg <= sfr_wdata[`CTRL_SLEEP_BIT];
      end
      dir_reg <= sfr_wdata[`CTRL_DIR_BIT];
    end
  end

  // acknowledge: software sets, engine clears once taken; a new set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else if (ctrl_wr && is_slave && sfr_wdata[`CTRL_ACK_BIT]) begin
      ack_reg <= 1'b1;
    end else if (evt.ack_taken) begin
      ack_reg <= 1'b0;
    end
  end

  // wake request: held until the engine reports the signal sent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_reg <= 1'b0;
    end else if (ctrl_wr && sfr_wdata[`CTRL_WAKE_BIT]) begin
      wake_reg <= 1'b1;
    end else if (evt.wake_sent) begin
      wake_reg <= 1'b0;
    end
  end

  // start request: master only, dropped on completion or error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_reg <= 1'b0;
    end else if (ctrl_wr && is_master && sfr_wdata[`CTRL_START_BIT]) begin
      start_reg <= 1'b1;
    end else if (evt.frame_end || evt.error_event) begin
      start_reg <= 1'b0;
    end
  end

  // interrupt pending flag: an event in the clearing cycle is kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_reg <= 1'b0;
    end else if (evt.irq_event) begin
      irq_flag_reg <= 1'b1;
    end else if (ctrl_wr && sfr_wdata[`CTRL_IRQ_FLAG_CLEAR_BIT]) begin
      irq_flag_reg <= 1'b0;
    end
  end

  // error status and error register, set beats clear per bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      error_flag_reg <= 1'b0;
      err_bits_reg   <= 5'h0;
    end else if (ctrl_wr && sfr_wdata[`CTRL_ERROR_FLAGS_CLEAR_BIT]) begin
      error_flag_reg <= evt.error_event || (|evt.error_bits);
      err_bits_reg   <= evt.error_bits;
    end else begin
      error_flag_reg <= error_flag_reg || evt.error_event || (|evt.error_bits);
      err_bits_reg   <= err_bits_reg | evt.error_bits;
    end
  end

  // frame settings: size keeps only its defined bits, id keeps six
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      size_reg <= `REG_RESET;
      div_reg  <= `REG_RESET;
      mul_reg  <= `REG_RESET;
      id_reg   <= 6'h00;
    end else if (core_wr) begin
      case (index_reg)
        `IDX_SIZE: size_reg <= sfr_wdata & `SIZE_WRITE_MASK;
        `IDX_DIV:  div_reg  <= sfr_wdata;
        `IDX_MUL:  mul_reg  <= sfr_wdata;
        `IDX_ID:   id_reg   <= sfr_wdata[5:0];
        default:   ;
      endcase
    end
  end

  // receive fill pointer restarts with each frame
  assign rx_ptr_eff = rx_frame_start ? 3'h0 : rx_ptr_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ptr_reg <= 3'h0;
    end else begin
      rx_ptr_reg <= rx_ptr_eff + 3'(drain);
    end
  end

  // a software write to a data byte stalls the drain for that cycle,
  // so the fifo backs up instead of the two writers colliding
  assign fifo_ready = enable_reg && !(core_wr && index_reg <= `IDX_DATA_LAST);
  assign drain      = fifo_valid && fifo_ready;

  // data byte buffer, one writer process per byte
  genvar gi;
  generate
    for (gi = 0; gi < `DATA_BYTES; gi++) begin : g_byte
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          data_byte_reg[gi] <= `REG_RESET;
        end else if (core_wr && index_reg == 8'(gi)) begin
          data_byte_reg[gi] <= sfr_wdata;
        end else if (drain && rx_ptr_eff == 3'(gi)) begin
          data_byte_reg[gi] <= fifo_byte;
        end
      end
      assign tx_bytes[gi*8 +: 8] = data_byte_reg[gi];
    end
  endgenerate

  // received bytes queue here while software or the buffer is busy
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_data   (rx_byte),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fifo_byte),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  // status view, slave-only bits masked in master role
  always_comb begin
    status_view    = 8'h00;
    status_view[7] = evt.bus_active;
    status_view[6] = evt.idle_timeout && is_slave;
    status_view[5] = evt.abort && is_slave;
    status_view[4] = evt.data_request_flag && is_slave;
    status_view[`ST_INT_BIT] = irq_flag_reg;
    status_view[`ST_ERR_BIT] = error_flag_reg;
    status_view[1] = evt.wakeup;
    status_view[0] = evt.done;
  end

  // indirect read mux; write-only action bits read as zero
  always_comb begin
    core_rdata = 8'h00;
    if (index_reg <= `IDX_DATA_LAST) begin
      core_rdata = data_byte_reg[index_reg[2:0]];
    end else begin
      case (index_reg)
        `IDX_CTRL: begin
          core_rdata[`CTRL_SLEEP_BIT] = sleep_reg && is_slave;
          core_rdata[`CTRL_DIR_BIT]   = dir_reg;
          core_rdata[`CTRL_ACK_BIT]   = ack_reg && is_slave;
          core_rdata[`CTRL_WAKE_BIT]  = wake_reg;
          core_rdata[`CTRL_START_BIT] = start_reg && is_master;
        end
        `IDX_STATUS: core_rdata = status_view;
        `IDX_ERROR:  core_rdata = {3'h0, is_slave ? err_bits_reg : err_bits_reg & ~`ERR_SLAVE_MASK};
        `IDX_SIZE:   core_rdata = size_reg;
        `IDX_DIV:    core_rdata = div_reg;
        `IDX_MUL:    core_rdata = mul_reg;
        `IDX_ID:     core_rdata = {2'h0, id_reg};
        default:     core_rdata = 8'h00;
      endcase
    end
  end

  // registered read data, answer one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `SFR_CFG_ADDR:   sfr_rdata <= {enable_reg, role_reg, auto_baud_select_reg, 5'h00};
        `SFR_INDEX_ADDR: sfr_rdata <= index_reg;
        `SFR_DATA_ADDR:  sfr_rdata <= core_rdata;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  // settings handed to the engine, all straight from registers
  assign ctrl.iface_enable             = enable_reg;
  assign ctrl.master_role              = is_master;
  assign ctrl.auto_baud_active         = auto_baud_reg;
  assign ctrl.frame_direction          = dir_reg;
  assign ctrl.sleep_request            = sleep_reg;
  assign ctrl.stop_pulse               = stop_reg;
  assign ctrl.data_acknowledge         = ack_reg;
  assign ctrl.wake_signal_request      = wake_reg;
  assign ctrl.frame_start_request      = start_reg;
  assign ctrl.enhanced_checksum_select = size_reg[`SIZE_ENH_BIT];
  assign ctrl.frame_length             = size_reg[3:0];
  assign ctrl.baud_divider_low_bits    = div_reg;
  assign ctrl.baud_prescaler           = mul_reg[7:6];
  assign ctrl.baud_multiplier          = mul_reg[5:1];
  assign ctrl.baud_divider_msb         = mul_reg[0];
  assign ctrl.frame_id                 = id_reg;
endmodule
`default_nettype wire

/* bench/lin_control_register_set_sva.sv */
// port-level assertions for the lin register set
`include "lin_ctrl_regs.svh"
`default_nettype none
module lin_control_register_set_sva
  import lin_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // engine side
  input wire frame_ctrl_s ctrl,
  input wire engine_evt_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] index_reg; // shadow of the indirect index
  logic       cfg_wr;    // config register write
  logic       ctrl_wr;   // control register write
  logic       data_rd;   // read through the data port

  // shadow the index so that control accesses can be recognised here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_reg <= 8'h00;
    end else if (sfr_wr && sfr_addr == `SFR_INDEX_ADDR) begin
      index_reg <= sfr_wdata;
    end
  end
  assign cfg_wr  = sfr_wr && sfr_addr == `SFR_CFG_ADDR;
  assign ctrl_wr = sfr_wr && sfr_addr == `SFR_DATA_ADDR && index_reg == `IDX_CTRL;
  assign data_rd = sfr_rd && sfr_addr == `SFR_DATA_ADDR;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_enable_follows_cfg:
    assert property (cfg_wr |=> ctrl.iface_enable == $past(sfr_wdata[7])) else $error("enable bit wrong");
  a_role_follows_cfg:
    assert property (cfg_wr |=> ctrl.master_role == $past(sfr_wdata[6])) else $error("role bit wrong");
  a_auto_baud_select_slave_only:
    assert property (cfg_wr |=> ctrl.auto_baud_active == ($past(sfr_wdata[5]) && !$past(sfr_wdata[6])))
    else $error("auto baud wrong");
  a_cfg_low_zero:
    assert property (sfr_rd && sfr_addr == `SFR_CFG_ADDR |=> sfr_rdata[4:0] == 5'h00) else $error("cfg low bits set");
  a_stop_one_cycle:
    assert property (ctrl_wr && sfr_wdata[7] |=> ctrl.stop_pulse == !$past(ctrl.master_role) ##1 !ctrl.stop_pulse)
    else $error("stop pulse wrong");
  a_start_master_only:
    assert property (ctrl_wr && sfr_wdata[0] |=> ctrl.frame_start_request == ($past(ctrl.master_role) ||
      $past(ctrl.frame_start_request) && !$past(evt.frame_end) && !$past(evt.error_event)))
    else $error("start request wrong");
  a_sleep_slave_only:
    assert property (ctrl_wr |=> ctrl.sleep_request ==
      ($past(ctrl.master_role) ? $past(ctrl.sleep_request) : $past(sfr_wdata[6])))
    else $error("sleep request wrong");
  a_start_end_clear:
    assert property (ctrl.frame_start_request && (evt.frame_end || evt.error_event) && !ctrl_wr
      |=> !ctrl.frame_start_request) else $error("start not cleared");
  a_wake_sent_clear:
    assert property (evt.wake_sent && !ctrl_wr |=> !ctrl.wake_signal_request) else $error("wake not cleared");
  a_ack_taken_clear:
    assert property (evt.ack_taken && !ctrl_wr |=> !ctrl.data_acknowledge) else $error("ack not cleared");
  a_ctrl_wo_zero:
    assert property (data_rd && index_reg == `IDX_CTRL |=> sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'b00)
    else $error("write-only control bits read back");
  a_high_index_zero:
    assert property (data_rd && index_reg > `IDX_ID |=> sfr_rdata == 8'h00) else $error("unused index not zero");
endmodule

bind lin_control_register_set lin_control_register_set_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_lin_control_register_set_sva (
  .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ctrl(ctrl), .evt(evt));
`default_nettype wire

/* bench/lin_engine_model.sv */
// behavioural frame engine facing the register set
`default_nettype none
module lin_engine_model
  import lin_ctrl_pkg::*;
#(
  parameter int LATENCY = 12
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // settings and events
  input  wire frame_ctrl_s ctrl,
  output engine_evt_s      evt,
  // received byte stream
  output logic [7:0]       rx_byte,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  engine_evt_s manual;   // pulses commanded by the bench
  engine_evt_s auto_ev;  // answers to action requests
  int          wait_cnt; // cycles a request has waited

  assign evt = engine_evt_s'(manual | auto_ev);
  initial begin
    manual         = '0;
    rx_byte        = 8'h00;
    rx_valid       = 1'b0;
    rx_frame_start = 1'b0;
  end

  // answer start, wake and acknowledge after a slow fixed delay
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_ev  <= '0;
      wait_cnt <= 0;
    end else begin
      auto_ev  <= '0;
      wait_cnt <= (ctrl.frame_start_request || ctrl.wake_signal_request || ctrl.data_acknowledge) ? wait_cnt + 1 : 0;
      if (wait_cnt == LATENCY) begin
        auto_ev.frame_end <= ctrl.frame_start_request;
        auto_ev.wake_sent <= ctrl.wake_signal_request;
        auto_ev.ack_taken <= ctrl.data_acknowledge;
        wait_cnt          <= 0;
      end
    end
  end

  // one-cycle interrupt and error pulse
  task automatic pulse(input logic irq, input logic [4:0] errs);
    @(negedge clk);
    manual.irq_event  = irq;
    manual.error_bits = errs;
    @(negedge clk);
    manual = '0;
  endtask

  // stream bytes; gives up on a byte refused for 64 cycles
  task automatic send(input int n, input logic [7:0] base, output int sent);
    int w;
    sent = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_valid       = 1'b1;
      rx_byte        = base + 8'(i);
      rx_frame_start = (i == 0);
      for (w = 0; w < 64 && rx_ready !== 1'b1; w++) begin
        @(negedge clk);
        rx_frame_start = 1'b0;
      end
      if (w == 64) break;
      sent++;
    end
    @(negedge clk);
    // released line shows the inverse, not a stale byte
    rx_valid       = 1'b0;
    rx_byte        = ~rx_byte;
    rx_frame_start = 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the lin register set
`default_nettype none
module testbench
  import lin_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4; // small fifo keeps the fill short
  typedef struct packed {
    logic [7:0] idx; // core index
    logic [7:0] wd;  // value written
    logic [7:0] rd;  // value read back
  } row_s;
  logic        clk, rst_b, sfr_wr, sfr_rd, rx_valid, rx_ready, rx_frame_start;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rx_byte;
  logic [63:0] tx_bytes;
  frame_ctrl_s ctrl;
  engine_evt_s evt;
  int          n_mismatch, total_checks, stop_seen, acc;
  row_s        rows [10] = '{'{8'h00, 8'h5A, 8'h5A}, '{8'h07, 8'hC3, 8'hC3}, '{8'h0B, 8'hFF, 8'h8F},
    '{8'h0C, 8'h81, 8'h81}, '{8'h0D, 8'hA5, 8'hA5}, '{8'h0E, 8'hFF, 8'h3F}, '{8'h09, 8'hFF, 8'h00},
    '{8'h0A, 8'hFF, 8'h00}, '{8'h0F, 8'h12, 8'h00}, '{8'h08, 8'h20, 8'h20}};

  lin_control_register_set #(.FIFO_DEPTH(DEPTH)) i_lin_control_register_set (.clk(clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ctrl(ctrl), .evt(evt), .tx_bytes(tx_bytes), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_frame_start(rx_frame_start));
  lin_engine_model i_lin_engine_model (.clk(clk), .rst_b(rst_b), .ctrl(ctrl), .evt(evt), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame_start(rx_frame_start));

  always #2 clk = ~clk;
  // count cycles of the stop pulse
  always @(posedge clk) if (ctrl.stop_pulse === 1'b1) stop_seen++;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register port cycles, strobe raised and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(what, exp, sfr_rdata);
  endtask
  task automatic cwr(input logic [7:0] i, input logic [7:0] d);
    wr(8'hD3, i);
    wr(8'hD2, d);
  endtask
  task automatic cchk(input string what, input logic [7:0] i, input logic [7:0] exp);
    wr(8'hD3, i);
    rchk(what, 8'hD2, exp);
  endtask
  // bounded wait for a condition picked by k
  task automatic wait_for(input int k);
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if ((k == 0 && ctrl.data_acknowledge === 1'b0) || (k == 1 && ctrl.wake_signal_request === 1'b0) ||
          (k == 2 && ctrl.frame_start_request === 1'b0) || (k == 3 && rx_ready === 1'b1) ||
          (k == 4 && tx_bytes === 64'h3736_3534_3332_3130)) break;
    end
    if (i == 100) begin
      n_mismatch++;
      $display("Error wait %0d expected done seen timeout", k);
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {clk, rst_b, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {n_mismatch, total_checks, stop_seen} = '0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    rchk("config", 8'hC9, 8'h60);
    rchk("unmapped", 8'h55, 8'h00);
    chk("tx_bytes", 64'h0, tx_bytes);
    $display("test reset done");
    foreach (rows[i]) begin
      cwr(rows[i].idx, rows[i].wd);
      cchk("core", rows[i].idx, rows[i].rd);
    end
    cchk("id kept", 8'h0E, 8'h3F);
    chk("tx_bytes", 64'hC300_0000_0000_005A, tx_bytes);
    $display("test table done");
    wr(8'hC9, 8'hFF);
    rchk("config", 8'hC9, 8'hE0);
    chk("enable", 1, ctrl.iface_enable);
    chk("auto_baud_select", 0, ctrl.auto_baud_active);
    wr(8'hC9, 8'hA0);
    chk("role", 0, ctrl.master_role);
    chk("auto_baud_select", 1, ctrl.auto_baud_active);
    cwr(8'h08, 8'h01);
    cchk("slave start", 8'h08, 8'h00);
    cwr(8'h08, 8'hD0);
    cchk("slave ctrl", 8'h08, 8'h50);
    chk("stop", 1, stop_seen);
    wait_for(0);
    cchk("ack done", 8'h08, 8'h40);
    $display("test slave control done");
    i_lin_engine_model.pulse(1'b1, 5'h1C);
    cchk("status", 8'h09, 8'h0C);
    cchk("errors", 8'h0A, 8'h1C);
    cwr(8'h08, 8'h08);
    cchk("irq clear", 8'h09, 8'h04);
    cwr(8'h08, 8'h04);
    cchk("err clear", 8'h09, 8'h00);
    cchk("err flags", 8'h0A, 8'h00);
    cwr(8'h08, 8'h02);
    cchk("wake", 8'h08, 8'h02);
    wait_for(1);
    cchk("wake done", 8'h08, 8'h00);
    $display("test events done");
    wr(8'hC9, 8'hC0);
    cwr(8'h0E, 8'h15);
    cwr(8'h0B, 8'h02);
    chk("frame setup", 16'h1502, {2'b00, ctrl.frame_id, ctrl.enhanced_checksum_select, 3'h0, ctrl.frame_length});
    cwr(8'h08, 8'h21);
    chk("start", 1, ctrl.frame_start_request);
    cchk("start read", 8'h08, 8'h21);
    wait_for(2);
    cchk("start done", 8'h08, 8'h20);
    i_lin_engine_model.pulse(1'b0, 5'h1C);
    cchk("master errors", 8'h0A, 8'h04);
    $display("test master start done");
    i_lin_engine_model.send(8, 8'h30, acc);
    wait_for(4);
    chk("frame bytes", 64'h3736_3534_3332_3130, tx_bytes);
    cchk("byte 8", 8'h07, 8'h37);
    wr(8'hC9, 8'h40);
    i_lin_engine_model.send(DEPTH + 4, 8'h80, acc);
    chk("refused", 1, acc < DEPTH + 4);
    chk("rx_ready", 0, rx_ready);
    wr(8'hC9, 8'hC0);
    wait_for(3);
    $display("test receive done");
    complete_run();
  end
endmodule
`default_nettype wire
